// *** logic/wdog_pkg.sv ***
package wdog_pkg;

   // ----------------------------------------
   // Register map (indices, byte address = 4 x index)
   // ----------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [11:0] CTL_IDX = 12'h03E;
   localparam logic [11:0] ARM_IDX = 12'h03F;
   localparam logic [11:0] STAT_IDX = 12'h040;
   localparam logic [11:0] CTL_ADDR = {CTL_IDX[9:0], 2'h0};
   localparam logic [11:0] ARM_ADDR = {ARM_IDX[9:0], 2'h0};
   localparam logic [11:0] STAT_ADDR = {STAT_IDX[9:0], 2'h0};

   // ----------------------------------------
   // Control field positions and values
   // ----------------------------------------
   localparam int WIN_BIT = 7;
   localparam int DBG_BIT = 6;
   localparam int MASK_BIT = 5;
   localparam int SWAI_BIT = 4;
   localparam int RSTP_BIT = 3;
   localparam int RATE_MSB = 2;
   localparam logic [2:0] RATE_OFF = 3'h0;
   localparam logic [2:0] RATE_MAX = 3'h7;
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;

   // Status register bits
   localparam int ST_EN_BIT = 0;
   localparam int ST_OPEN_BIT = 1;
   localparam int ST_ARMED_BIT = 2;
   localparam int ST_ONCE_BIT = 3;

   // ----------------------------------------
   // Counter, timing and bus answers
   // ----------------------------------------
   localparam int CNT_W = 17;
   localparam logic [4:0] SHIFT_MAX = 5'h10;
   localparam int REF_DIV_DEFAULT = 1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic {KEY_IDLE, KEY_FIRST_SEEN} key_state_e;

   // Timeout length as a power of two of reference ticks
   function automatic logic [4:0] rate_shift(input logic [2:0] rate);
      case (rate)
         3'h1: rate_shift = 5'h06;
         3'h2: rate_shift = 5'h08;
         3'h3: rate_shift = 5'h0A;
         3'h4: rate_shift = 5'h0C;
         3'h5: rate_shift = 5'h0E;
         3'h6: rate_shift = 5'h0F;
         default: rate_shift = 5'h10;
      endcase
   endfunction

   // Decoded register addresses
   function automatic logic addr_mapped(input logic [11:0] addr);
      addr_mapped = (addr == CTL_ADDR) || (addr == ARM_ADDR) || (addr == STAT_ADDR);
   endfunction

endpackage

// *** logic/ref_tick.sv ***
`timescale 1ns/10ps
// One-cycle enable pulse standing for one reference clock edge
module ref_tick #(
   parameter int DIV = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   output logic tick
);

   logic [15:0] div_q, div_d;
   logic tick_q, tick_d;

   // Divider next state
   always_comb
   begin
      if (div_q >= 16'(DIV - 1))
      begin
         div_d = 16'h0000;
         tick_d = 1'b1;
      end
      else
      begin
         div_d = div_q + 16'h0001;
         tick_d = 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         div_q <= 16'h0000;
         tick_q <= 1'b0;
      end
      else
      begin
         div_q <= div_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;

endmodule

// *** logic/axil_regs.sv ***
`timescale 1ns/10ps
// AXI4-Lite slave front end, one write and one read at a time
module axil_regs (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [7:0] rd_value,
   output logic wr_en,
   output logic [11:0] wr_addr,
   output logic [7:0] wr_data
);

   logic aw_held_q, aw_held_d, w_held_q, w_held_d, lane_q, lane_d;
   logic awready_q, wready_q, bvalid_q, bvalid_d, wr_en_q, wr_en_d;
   logic arready_q, rvalid_q, rvalid_d;
   logic [11:0] addr_q, addr_d;
   logic [7:0] data_q, data_d, rbyte_q, rbyte_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

   // Address and data latch in either order, answer after both
   always_comb
   begin
      aw_held_d = aw_held_q;
      w_held_d = w_held_q;
      addr_d = addr_q;
      data_d = data_q;
      lane_d = lane_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      wr_en_d = 1'b0;
      if (awvalid && awready_q)
      begin
         aw_held_d = 1'b1;
         addr_d = awaddr;
      end
      if (wvalid && wready_q)
      begin
         w_held_d = 1'b1;
         data_d = wdata[7:0];
         lane_d = wstrb[0];
      end
      if (bvalid_q && bready)
         bvalid_d = 1'b0;
      if (aw_held_q && w_held_q && !bvalid_q)
      begin
         aw_held_d = 1'b0;
         w_held_d = 1'b0;
         bvalid_d = 1'b1;
         wr_en_d = lane_q && wdog_pkg::addr_mapped(addr_q);
         bresp_d = wdog_pkg::addr_mapped(addr_q) ? wdog_pkg::RESP_OKAY : wdog_pkg::RESP_SLVERR;
      end
   end

   // Read taken and answered with the register value one edge later
   always_comb
   begin
      rvalid_d = rvalid_q;
      rbyte_d = rbyte_q;
      rresp_d = rresp_q;
      if (rvalid_q && rready)
         rvalid_d = 1'b0;
      if (arvalid && arready_q)
      begin
         rvalid_d = 1'b1;
         rbyte_d = rd_value;
         rresp_d = wdog_pkg::addr_mapped(araddr) ? wdog_pkg::RESP_OKAY : wdog_pkg::RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         addr_q <= 12'h000;
         data_q <= 8'h00;
         lane_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= 2'h0;
         wr_en_q <= 1'b0;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rbyte_q <= 8'h00;
         rresp_q <= 2'h0;
      end
      else
      begin
         aw_held_q <= aw_held_d;
         w_held_q <= w_held_d;
         awready_q <= !aw_held_d;
         wready_q <= !w_held_d;
         addr_q <= addr_d;
         data_q <= data_d;
         lane_q <= lane_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         wr_en_q <= wr_en_d;
         arready_q <= !rvalid_d;
         rvalid_q <= rvalid_d;
         rbyte_q <= rbyte_d;
         rresp_q <= rresp_d;
      end
   end

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rresp = rresp_q;
   assign rdata = {24'h000000, rbyte_q};
   assign wr_en = wr_en_q;
   assign wr_addr = addr_q;
   assign wr_data = data_q;

endmodule

// *** logic/windowed_watchdog_timer.sv ***
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
module windowed_watchdog_timer #(
   parameter int REF_DIV = wdog_pkg::REF_DIV_DEFAULT
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axil_awaddr,
   input wire logic [2:0] s_axil_awprot,
   input wire logic s_axil_awvalid,
   output logic s_axil_awready,
   input wire logic [31:0] s_axil_wdata,
   input wire logic [3:0] s_axil_wstrb,
   input wire logic s_axil_wvalid,
   output logic s_axil_wready,
   output logic [1:0] s_axil_bresp,
   output logic s_axil_bvalid,
   input wire logic s_axil_bready,
   input wire logic [11:0] s_axil_araddr,
   input wire logic [2:0] s_axil_arprot,
   input wire logic s_axil_arvalid,
   output logic s_axil_arready,
   output logic [31:0] s_axil_rdata,
   output logic [1:0] s_axil_rresp,
   output logic s_axil_rvalid,
   input wire logic s_axil_rready,
   input wire logic special_mode,
   input wire logic wait_mode,
   input wire logic stop_mode,
   input wire logic debug_active,
   input wire logic [3:0] nv_option,
   output logic wdog_reset_req,
   output logic pit_freeze
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic tick;
   logic wr_en;
   logic [11:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] rd_value;

   logic win_q, win_d;
   logic dbg_q, dbg_d;
   logic swai_q, swai_d;
   logic rstp_q, rstp_d;
   logic [2:0] rate_q, rate_d;
   logic once_q, once_d;
   logic boot_q, boot_d;
   logic [wdog_pkg::CNT_W-1:0] cnt_q, cnt_d;
   wdog_pkg::key_state_e key_q, key_d;
   logic rst_req_q, rst_req_d;
   logic pit_freeze_q, pit_freeze_d;

   logic enabled, override, eff_win, frozen, win_open;
   logic ctl_wr, arm_wr, cfg_wr, restart;
   logic [4:0] eff_shift;
   logic [wdog_pkg::CNT_W-1:0] period, open_at;

   // ----------------------------------------
   // Bus slave and reference tick
   // ----------------------------------------
   axil_regs u_bus (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(s_axil_awaddr),
      .awvalid(s_axil_awvalid),
      .awready(s_axil_awready),
      .wdata(s_axil_wdata),
      .wstrb(s_axil_wstrb),
      .wvalid(s_axil_wvalid),
      .wready(s_axil_wready),
      .bresp(s_axil_bresp),
      .bvalid(s_axil_bvalid),
      .bready(s_axil_bready),
      .araddr(s_axil_araddr),
      .arvalid(s_axil_arvalid),
      .arready(s_axil_arready),
      .rdata(s_axil_rdata),
      .rresp(s_axil_rresp),
      .rvalid(s_axil_rvalid),
      .rready(s_axil_rready),
      .rd_value(rd_value),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data)
   );

   ref_tick #(
      .DIV(REF_DIV)
   ) u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick)
   );

   // ----------------------------------------
   // Effective operating point
   // ----------------------------------------

   // Enable, debug override, period and window edge
   always_comb
   begin
      enabled = (rate_q != wdog_pkg::RATE_OFF);
      override = enabled && debug_active && !dbg_q && special_mode;
      eff_shift = override ? wdog_pkg::SHIFT_MAX : wdog_pkg::rate_shift(rate_q);
      eff_win = win_q && !override;
      period = wdog_pkg::CNT_W'(17'h00001 << eff_shift);
      open_at = period - (period >> 2);
      win_open = (cnt_q >= open_at);
      frozen = (debug_active && dbg_q)
         || (stop_mode && !rstp_q)
         || (wait_mode && swai_q);
   end

   // Write decode
   always_comb
   begin
      ctl_wr = wr_en && (wr_addr == wdog_pkg::CTL_ADDR);
      arm_wr = wr_en && (wr_addr == wdog_pkg::ARM_ADDR);
      cfg_wr = ctl_wr && !wr_data[wdog_pkg::MASK_BIT]
         && (special_mode || !once_q);
   end

   // ----------------------------------------
   // Control register
   // ----------------------------------------

   // Field updates under write permissions
   always_comb
   begin
      win_d = win_q;
      dbg_d = dbg_q;
      swai_d = swai_q;
      rstp_d = rstp_q;
      rate_d = rate_q;
      once_d = once_q;
      boot_d = 1'b0;
      if (boot_q)
      begin
         if (special_mode)
         begin
            rate_d = wdog_pkg::RATE_MAX;
            win_d = 1'b0;
         end
         else
         begin
            rate_d = ~nv_option[2:0];
            win_d = ~nv_option[3];
         end
      end
      else
      begin
         if (ctl_wr)
         begin
            if (special_mode)
               dbg_d = wr_data[wdog_pkg::DBG_BIT];
            else
               dbg_d = dbg_q | wr_data[wdog_pkg::DBG_BIT];
         end
         if (cfg_wr)
         begin
            swai_d = wr_data[wdog_pkg::SWAI_BIT];
            rstp_d = wr_data[wdog_pkg::RSTP_BIT];
            if (special_mode)
            begin
               rate_d = wr_data[wdog_pkg::RATE_MSB:0];
               win_d = wr_data[wdog_pkg::WIN_BIT];
            end
            else
            begin
               once_d = 1'b1;
               if (wr_data[wdog_pkg::RATE_MSB:0] != wdog_pkg::RATE_OFF)
                  rate_d = wr_data[wdog_pkg::RATE_MSB:0];
               if (wr_data[wdog_pkg::WIN_BIT])
                  win_d = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         win_q <= 1'b0;
         dbg_q <= 1'b0;
         swai_q <= 1'b0;
         rstp_q <= 1'b0;
         rate_q <= 3'h0;
         once_q <= 1'b0;
         boot_q <= 1'b1;
      end
      else
      begin
         win_q <= win_d;
         dbg_q <= dbg_d;
         swai_q <= swai_d;
         rstp_q <= rstp_d;
         rate_q <= rate_d;
         once_q <= once_d;
         boot_q <= boot_d;
      end
   end

   // ----------------------------------------
   // Counter, key sequence and reset request
   // ----------------------------------------

   // Restart sources other than the key pair
   always_comb
   begin
      restart = boot_q
         || (cfg_wr && wr_data[wdog_pkg::RATE_MSB:0] != wdog_pkg::RATE_OFF)
         || (!dbg_q && dbg_d);
   end

   // Timeout count and arm register service
   always_comb
   begin
      cnt_d = cnt_q;
      key_d = key_q;
      rst_req_d = 1'b0;
      if (!enabled)
      begin
         cnt_d = '0;
         key_d = wdog_pkg::KEY_IDLE;
      end
      else
      begin
         if (wait_mode && swai_q)
         begin
            cnt_d = '0;
         end
         else if (tick && !frozen)
         begin
            if (cnt_q >= period - 17'h00001)
            begin
               cnt_d = '0;
               key_d = wdog_pkg::KEY_IDLE;
               rst_req_d = 1'b1;
            end
            else
               cnt_d = cnt_q + 17'h00001;
         end
         if (arm_wr)
         begin
            case (wr_data)
               wdog_pkg::KEY_FIRST:
               begin
                  if (eff_win && !win_open)
                     rst_req_d = 1'b1;
                  else
                     key_d = wdog_pkg::KEY_FIRST_SEEN;
               end
               wdog_pkg::KEY_SECOND:
               begin
                  if (eff_win && !win_open)
                     rst_req_d = 1'b1;
                  else if (key_q == wdog_pkg::KEY_FIRST_SEEN)
                  begin
                     cnt_d = '0;
                     key_d = wdog_pkg::KEY_IDLE;
                  end
               end
               default:
               begin
                  rst_req_d = 1'b1;
               end
            endcase
         end
         if (rst_req_d)
         begin
            cnt_d = '0;
            key_d = wdog_pkg::KEY_IDLE;
         end
      end
      if (restart)
      begin
         cnt_d = '0;
         key_d = wdog_pkg::KEY_IDLE;
      end
   end

   // Periodic timer halt follows the debug-stop setting
   always_comb
   begin
      pit_freeze_d = debug_active && dbg_d;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_q <= '0;
         key_q <= wdog_pkg::KEY_IDLE;
         rst_req_q <= 1'b0;
         pit_freeze_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         key_q <= key_d;
         rst_req_q <= rst_req_d;
         pit_freeze_q <= pit_freeze_d;
      end
   end

   // ----------------------------------------
   // Read data and outputs
   // ----------------------------------------

   // Read mux on the incoming read address
   always_comb
   begin
      rd_value = 8'h00;
      case (s_axil_araddr)
         wdog_pkg::CTL_ADDR:
         begin
            rd_value[wdog_pkg::WIN_BIT] = win_q;
            rd_value[wdog_pkg::DBG_BIT] = dbg_q;
            rd_value[wdog_pkg::SWAI_BIT] = swai_q;
            rd_value[wdog_pkg::RSTP_BIT] = rstp_q;
            rd_value[wdog_pkg::RATE_MSB:0] = rate_q;
         end
         wdog_pkg::ARM_ADDR:
         begin
            rd_value = 8'h00;
         end
         wdog_pkg::STAT_ADDR:
         begin
            rd_value[wdog_pkg::ST_EN_BIT] = enabled;
            rd_value[wdog_pkg::ST_OPEN_BIT] = win_open;
            rd_value[wdog_pkg::ST_ARMED_BIT] = (key_q == wdog_pkg::KEY_FIRST_SEEN);
            rd_value[wdog_pkg::ST_ONCE_BIT] = once_q;
         end
         default:
         begin
            rd_value = 8'h00;
         end
      endcase
   end

   assign wdog_reset_req = rst_req_q;
   assign pit_freeze = pit_freeze_q;

endmodule

// *** dv/windowed_watchdog_timer_checker.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// Port-level checker for the watchdog
// ----------------------------------------
module windowed_watchdog_timer_checker #(
   parameter int REF_DIV = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axil_awaddr,
   input wire logic s_axil_awvalid,
   input wire logic s_axil_awready,
   input wire logic s_axil_wvalid,
   input wire logic s_axil_wready,
   input wire logic [1:0] s_axil_bresp,
   input wire logic s_axil_bvalid,
   input wire logic [11:0] s_axil_araddr,
   input wire logic s_axil_arvalid,
   input wire logic s_axil_arready,
   input wire logic [31:0] s_axil_rdata,
   input wire logic [1:0] s_axil_rresp,
   input wire logic s_axil_rvalid,
   input wire logic special_mode,
   input wire logic debug_active,
   input wire logic wdog_reset_req,
   input wire logic pit_freeze
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Reset request shape and reset behaviour
   property p_req_pulse;
      wdog_reset_req |=> !wdog_reset_req [*2];
   endproperty
   a_req_pulse: assert property (p_req_pulse) else $error("reset request not single");
   property p_req_after_reset;
      $rose(aresetn) |-> !wdog_reset_req && !pit_freeze;
   endproperty
   a_req_after_reset: assert property (p_req_after_reset) else $error("output after reset");

   // Debug freeze of both counters
   property p_freeze_cause;
      pit_freeze |-> $past(debug_active);
   endproperty
   a_freeze_cause: assert property (p_freeze_cause) else $error("freeze without debug");
   property p_freeze_no_timeout;
      pit_freeze && $past(pit_freeze) && $past(pit_freeze, 2) && !$past(s_axil_bvalid)
         && !$past(s_axil_bvalid, 2) |-> !wdog_reset_req;
   endproperty
   a_freeze_no_timeout: assert property (p_freeze_no_timeout) else $error("timeout frozen");
   property p_dbg_set_only;
      !special_mode ##1 (pit_freeze && debug_active && !special_mode) |=> pit_freeze;
   endproperty
   a_dbg_set_only: assert property (p_dbg_set_only) else $error("debug stop cleared");

   // Register path
   property p_arm_read_zero;
      s_axil_arvalid && s_axil_arready && s_axil_araddr == wdog_pkg::ARM_ADDR |=>
         s_axil_rvalid && s_axil_rdata == 32'h0 && s_axil_rresp == wdog_pkg::RESP_OKAY;
   endproperty
   a_arm_read_zero: assert property (p_arm_read_zero) else $error("arm read not zero");
   property p_read_width;
      s_axil_rvalid |-> s_axil_rdata[31:8] == 24'h0;
   endproperty
   a_read_width: assert property (p_read_width) else $error("upper read bits set");
   property p_arm_write_ok;
      s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready
         && s_axil_awaddr == wdog_pkg::ARM_ADDR |-> ##2 s_axil_bvalid
         && s_axil_bresp == wdog_pkg::RESP_OKAY;
   endproperty
   a_arm_write_ok: assert property (p_arm_write_ok) else $error("arm write refused");

   // Main scenarios reached
   c_req: cover property (wdog_reset_req);
   c_freeze: cover property (pit_freeze && debug_active);
   c_arm_read: cover property (s_axil_arvalid && s_axil_araddr == wdog_pkg::ARM_ADDR);
endmodule

bind windowed_watchdog_timer windowed_watchdog_timer_checker #(.REF_DIV(REF_DIV))
   u_windowed_watchdog_timer_checker (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid,
   .s_axil_awready, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid,
   .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp,
   .s_axil_rvalid, .special_mode, .debug_active, .wdog_reset_req, .pit_freeze);

// *** dv/test_windowed_watchdog_timer.sv ***
`timescale 1ns/10ps
module test_windowed_watchdog_timer;
   logic aclk, aresetn, s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
   logic s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid;
   logic s_axil_rready, special_mode, wait_mode, stop_mode, debug_active;
   logic wdog_reset_req, pit_freeze, once_m;
   logic [11:0] s_axil_awaddr, s_axil_araddr;
   logic [31:0] s_axil_wdata, s_axil_rdata, rd_q, rnd;
   logic [1:0] s_axil_bresp, s_axil_rresp, resp_q;
   logic [3:0] nv_option;
   logic [7:0] ctl_m;
   int num_errors = 0, total_checks = 0, pulses = 0, cyc = 0, p0, n;
   int per_t [5] = '{64, 256, 1024, 4096, 16384};

   windowed_watchdog_timer #(.REF_DIV(1)) u_windowed_watchdog_timer (.aclk, .aresetn,
      .s_axil_awaddr, .s_axil_awprot(3'h0), .s_axil_awvalid, .s_axil_awready,
      .s_axil_wdata, .s_axil_wstrb(4'hF), .s_axil_wvalid, .s_axil_wready, .s_axil_bresp,
      .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arprot(3'h0),
      .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid,
      .s_axil_rready, .special_mode, .wait_mode, .stop_mode, .debug_active, .nv_option,
      .wdog_reset_req, .pit_freeze);

   // Clock, pulse counting and hang guard
   initial
   begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      if (wdog_reset_req === 1'b1) pulses <= pulses + 1;
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         num_errors++;
         print_verdict();
      end
   end

   // ----------------------------------------
   // Reporting and bus tasks
   // ----------------------------------------
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic axi_write(input logic [11:0] a, input logic [7:0] d);
      @(posedge aclk);
      s_axil_awaddr <= a;
      s_axil_wdata <= {24'h0, d};
      s_axil_awvalid <= 1'b1;
      s_axil_wvalid <= 1'b1;
      s_axil_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axil_awready) s_axil_awvalid <= 1'b0;
         if (s_axil_wready) s_axil_wvalid <= 1'b0;
      end
      while (!s_axil_bvalid);
      resp_q = s_axil_bresp;
      s_axil_bready <= 1'b0;
   endtask
   task automatic axi_read(input logic [11:0] a);
      @(posedge aclk);
      s_axil_araddr <= a;
      s_axil_arvalid <= 1'b1;
      s_axil_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axil_arready) s_axil_arvalid <= 1'b0;
      end
      while (!s_axil_rvalid);
      rd_q = s_axil_rdata;
      resp_q = s_axil_rresp;
      s_axil_rready <= 1'b0;
   endtask

   // ----------------------------------------
   // Control register model and helpers
   // ----------------------------------------
   task automatic ctl_model(input logic [7:0] v);
      ctl_m[6] = special_mode ? v[6] : (ctl_m[6] | v[6]);
      if (!v[5] && (special_mode || !once_m))
      begin
         if (special_mode || v[2:0] != 3'h0) ctl_m[2:0] = v[2:0];
         if (special_mode || v[7]) ctl_m[7] = v[7];
         ctl_m[4:3] = v[4:3];
         once_m = 1'b1;
      end
   endtask
   task automatic set_ctl(input logic [7:0] v);
      axi_write(wdog_pkg::CTL_ADDR, v);
      check(resp_q, wdog_pkg::RESP_OKAY);
      ctl_model(v);
      axi_read(wdog_pkg::CTL_ADDR);
      check(rd_q, {24'h0, ctl_m});
   endtask
   task automatic arm_bad();
      logic [7:0] k;
      rnd = lfsr(rnd);
      k = rnd[7:0];
      if (k == wdog_pkg::KEY_FIRST || k == wdog_pkg::KEY_SECOND) k = 8'h00;
      axi_write(wdog_pkg::ARM_ADDR, k);
   endtask
   task automatic arm(input logic [7:0] v);
      axi_write(wdog_pkg::ARM_ADDR, v);
   endtask
   task automatic wait_pulse();
      p0 = pulses;
      n = 0;
      while (pulses == p0 && n < 20000)
      begin
         @(posedge aclk);
         n++;
      end
   endtask
   task automatic do_reset(input logic s, input logic [3:0] nv);
      aresetn <= 1'b0;
      special_mode <= s;
      nv_option <= nv;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      ctl_m = s ? 8'h07 : {~nv[3], 4'h0, ~nv[2:0]};
      once_m = 1'b0;
      axi_read(wdog_pkg::CTL_ADDR);
      check(rd_q, {24'h0, ctl_m});
   endtask

   // Main sequence
   initial
   begin
      rnd = 32'hBF3E0460;
      {s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} <= 5'h0;
      {wait_mode, stop_mode, debug_active} <= 3'h0;
      s_axil_awaddr <= 12'h0;
      s_axil_araddr <= 12'h0;
      s_axil_wdata <= 32'h0;
      do_reset(1'b0, 4'hF);
      axi_read(wdog_pkg::ARM_ADDR);
      check(rd_q, 32'h0);
      rnd = lfsr(rnd);
      axi_read({rnd[7:0], 4'h4});
      check(resp_q, wdog_pkg::RESP_SLVERR);
      p0 = pulses;
      arm_bad();
      repeat (8) @(posedge aclk);
      check(pulses - p0, 0);
      set_ctl(8'h60);
      set_ctl(8'h20);
      debug_active <= 1'b1;
      repeat (3) @(posedge aclk);
      check(pit_freeze, 1'b1);
      debug_active <= 1'b0;
      set_ctl(8'h19);
      set_ctl(8'h87);
      p0 = pulses;
      wait_mode <= 1'b1;
      repeat (300) @(posedge aclk);
      check(pulses - p0, 0);
      wait_mode <= 1'b0;
      stop_mode <= 1'b1;
      wait_pulse();
      check(n >= 60 && n <= 68, 1'b1);
      stop_mode <= 1'b0;
      p0 = pulses;
      repeat (6)
      begin
         repeat (12) @(posedge aclk);
         arm(wdog_pkg::KEY_SECOND);
         arm(wdog_pkg::KEY_FIRST);
         arm(wdog_pkg::KEY_SECOND);
      end
      check(pulses - p0, 0);
      debug_active <= 1'b1;
      repeat (300) @(posedge aclk);
      check(pulses - p0, 0);
      debug_active <= 1'b0;
      arm_bad();
      repeat (4) @(posedge aclk);
      check(pulses - p0, 1);
      do_reset(1'b0, 4'h7);
      set_ctl(8'h00);
      set_ctl(8'h01);
      p0 = pulses;
      arm_bad();
      repeat (4) @(posedge aclk);
      check(pulses - p0, 0);
      do_reset(1'b1, 4'hF);
      for (int c = 1; c < 6; c++)
      begin
         axi_write(wdog_pkg::CTL_ADDR, c[7:0]);
         ctl_model(c[7:0]);
         wait_pulse();
         check(n >= per_t[c-1] - 4 && n <= per_t[c-1] + 4, 1'b1);
      end
      axi_write(wdog_pkg::CTL_ADDR, 8'h01);
      ctl_model(8'h01);
      repeat (20) @(posedge aclk);
      stop_mode <= 1'b1;
      repeat (100) @(posedge aclk);
      stop_mode <= 1'b0;
      wait_pulse();
      check(n >= 42 && n <= 50, 1'b1);
      set_ctl(8'h82);
      p0 = pulses;
      arm(wdog_pkg::KEY_FIRST);
      repeat (4) @(posedge aclk);
      check(pulses - p0, 1);
      repeat (195) @(posedge aclk);
      p0 = pulses;
      arm(wdog_pkg::KEY_FIRST);
      arm(wdog_pkg::KEY_FIRST);
      arm(wdog_pkg::KEY_SECOND);
      repeat (4) @(posedge aclk);
      check(pulses - p0, 0);
      arm(wdog_pkg::KEY_FIRST);
      repeat (4) @(posedge aclk);
      check(pulses - p0, 1);
      debug_active <= 1'b1;
      arm(wdog_pkg::KEY_FIRST);
      arm(wdog_pkg::KEY_SECOND);
      repeat (4) @(posedge aclk);
      check(pulses - p0, 1);
      debug_active <= 1'b0;
      print_verdict();
   end
endmodule
